// >>> rtl/ekr_top.sv
// The implementer's own choice: strobed register access.
`include "ekr_params.svh"

// Function
// - first knee at programmed row count
// - second knee at programmed row count
// - manual mode splits into three intervals
// - exposure writes stored now, applied next frame; read mode writes apply at once
// - second level lasts total over two-power
// - third level likewise; first gets remainder
// - auto-adjust bit picks knee placement
// - single-knee enable bit, default clear
// - total rows used while AEC disabled
// - soft reset pulses logic reset 15 cycles
// - auto block reset pulses 15 cycles
// - row binning by one, two, four
// - column binning divides pixel clock
// - row flip reverses readout direction
module ekr_top (
  input  wire logic        ref_clk_i,      // Master clock.
  input  wire logic        arst_n_i,       // Async reset, low.
  input  wire logic [7:0]  addr_i,         // Register address.
  input  wire logic [15:0] wdata_i,        // Write data.
  input  wire logic        wr_i,           // Write strobe.
  input  wire logic        rd_i,           // Read strobe.
  output logic      [15:0] rdata_o,        // Read data, next cycle.
  input  wire logic        hdr_en_i,       // High dynamic range on.
  input  wire logic        aec_en_i,       // Auto exposure on.
  input  wire logic [14:0] aec_rows_i,     // Auto exposure length.
  input  wire logic        frame_start_i,  // Frame start pulse.
  input  wire logic        row_tick_i,     // One exposure row done.
  input  wire logic        line_done_i,    // One readout row done.
  input  wire logic [8:0]  row_start_i,    // First window row.
  input  wire logic [8:0]  win_height_i,   // Window height.
  output logic             exposing_o,     // Integration running.
  output logic      [1:0]  gate_level_o,   // Saturation gate level.
  output logic      [14:0] t1_rows_o,      // First interval rows.
  output logic      [14:0] t2_rows_o,      // Second interval rows.
  output logic      [14:0] t3_rows_o,      // Third interval rows.
  output logic      [1:0]  row_bin_o,      // Row binning code.
  output logic      [1:0]  col_bin_o,      // Column binning code.
  output logic             row_flip_o,     // Rows read bottom up.
  output logic             pix_clk_en_o,   // Pixel clock enable.
  output logic      [9:0]  row_addr_o,     // Row being read.
  output logic             logic_rst_n_o,  // Digital logic reset.
  output logic             auto_rst_n_o    // Auto block reset.
);
  import ekr_pkg::*;

  // ========================================================
  // State of the block, apart from the reset pulse stretchers, in one record.
  typedef struct packed {
    logic [14:0] knee1;      // First knee row count.
    logic [14:0] knee2;      // Second knee row count.
    logic [3:0]  t2_exp;     // Second interval exponent.
    logic [3:0]  t3_exp;     // Third interval exponent.
    logic        auto_adj;   // Knee auto adjust.
    logic        single;     // Single knee mode.
    logic [14:0] total;      // Total integration rows.
    ekr_bin_t    row_bin;    // Row binning.
    ekr_bin_t    col_bin;    // Column binning.
    logic        row_flip;   // Row flip.
    logic [15:0] rd_data;    // Read data holding stage.
    logic [14:0] w_t1;       // Working first interval.
    logic [14:0] w_t2;       // Working second interval.
    logic [14:0] w_t3;       // Working third interval.
    logic [14:0] w_total;    // Working total length.
    ekr_state_t  state;      // Sequencer state.
    logic [14:0] row_cnt;    // Rows integrated so far.
    ekr_gate_t   gate;       // Current gate level.
    logic [1:0]  pix_div;    // Pixel clock divider.
    logic        pix_en;     // Pixel clock enable.
    logic [9:0]  row_addr;   // Readout row address.
  } ekr_top_t;

  ekr_top_t st;       // Registered state.
  ekr_top_t next_st;  // Next state.

  logic wr_srst;      // Write to the soft reset register.
  logic srst_all;     // Request for the full logic reset.
  logic srst_auto;    // Request for the auto block reset.
  logic logic_rst_n;  // Stretched full logic reset.

  // ========================================================
  // Helper functions.

  // Subtraction that stops at zero instead of wrapping.
  function automatic logic [14:0] sat_sub(
    input logic [14:0] a,
    input logic [14:0] b
  );
    sat_sub = (a > b) ? (a - b) : 15'h0000;
  endfunction

  // Total times one-half to the given power.
  function automatic logic [14:0] ratio_rows(
    input logic [14:0] total,
    input logic [3:0]  expo
  );
    ratio_rows = total >> expo;
  endfunction

  // Step size of one output row for a binning code.
  function automatic logic [9:0] bin_step(input ekr_bin_t code);
    case (code)
      EKR_BIN_2: bin_step = 10'h002;
      EKR_BIN_4: bin_step = 10'h004;
      default:   bin_step = 10'h001;
    endcase
  endfunction

  // Gate level for a row position in the working intervals.
  function automatic ekr_gate_t level_for(
    input logic [14:0] cnt,
    input logic [14:0] t1,
    input logic [14:0] t2
  );
    logic [15:0] edge2;
    edge2 = {1'b0, t1} + {1'b0, t2};
    if ({1'b0, cnt} < {1'b0, t1}) begin
      level_for = EKR_GATE_FIRST;
    end else if ({1'b0, cnt} < edge2) begin
      level_for = EKR_GATE_SEC;
    end else begin
      level_for = EKR_GATE_THIRD;
    end
  endfunction

  // ========================================================
  // Soft reset pulse stretchers.

  // Both reset bits are write-one strobes, never stored.
  assign wr_srst   = wr_i && (addr_i == `EKR_OFS_SRST);
  assign srst_all  = wr_srst && wdata_i[`EKR_SRST_ALL];
  assign srst_auto = wr_srst && wdata_i[`EKR_SRST_AUTO];

  // Full digital reset; the register file itself is spared.
  ekr_rst_pulse u_rst_all (
    .ref_clk_i (ref_clk_i),
    .arst_n_i  (arst_n_i),
    .trigger_i (srst_all),
    .rst_n_o   (logic_rst_n)
  );

  // Reset of the automatic gain and exposure logic only.
  ekr_rst_pulse u_rst_auto (
    .ref_clk_i (ref_clk_i),
    .arst_n_i  (arst_n_i),
    .trigger_i (srst_auto),
    .rst_n_o   (auto_rst_n_o)
  );

  // ========================================================
  // Next-state logic.
  always_comb begin
    logic [14:0] tot;   // Exposure length for the new frame.
    logic [14:0] a2;    // Auto second interval.
    logic [14:0] a3;    // Auto third interval.
    logic [14:0] nc;    // Row count after a tick.
    tot = 15'h0000;
    a2  = 15'h0000;
    a3  = 15'h0000;
    nc  = 15'h0000;
    next_st = st;

    // Register writes land at once, no shadow copy.
    if (wr_i) begin
      case (addr_i)
        `EKR_OFS_KNEE1: begin
          next_st.knee1 = wdata_i[14:0];
        end
        `EKR_OFS_KNEE2: begin
          next_st.knee2 = wdata_i[14:0];
        end
        `EKR_OFS_RATIO: begin
          next_st.t2_exp   = wdata_i[`EKR_RATIO_T2_LSB +: 4];
          next_st.t3_exp   = wdata_i[`EKR_RATIO_T3_LSB +: 4];
          next_st.auto_adj = wdata_i[`EKR_RATIO_AUTO];
          next_st.single   = wdata_i[`EKR_RATIO_SINGLE];
        end
        `EKR_OFS_TOTAL: begin
          next_st.total = wdata_i[14:0];
        end
        `EKR_OFS_READMODE: begin
          next_st.row_bin  =
            ekr_bin_t'(wdata_i[`EKR_RM_ROWBIN_LSB +: 2]);
          next_st.col_bin  =
            ekr_bin_t'(wdata_i[`EKR_RM_COLBIN_LSB +: 2]);
          next_st.row_flip = wdata_i[`EKR_RM_ROWFLIP];
        end
        // Other offsets, the reset strobes among them, store nothing.
        default: begin
        end
      endcase
    end

    // Read data stands for exactly one cycle after the strobe.
    next_st.rd_data = 16'h0000;
    if (rd_i) begin
      case (addr_i)
        `EKR_OFS_KNEE1: next_st.rd_data = {1'b0, st.knee1};
        `EKR_OFS_KNEE2: next_st.rd_data = {1'b0, st.knee2};
        `EKR_OFS_RATIO: begin
          next_st.rd_data = {6'h00, st.single, st.auto_adj,
                             st.t3_exp, st.t2_exp};
        end
        `EKR_OFS_TOTAL: next_st.rd_data = {1'b0, st.total};
        // Self-clearing reset bits always read back as zero.
        `EKR_OFS_SRST:  next_st.rd_data = 16'h0000;
        `EKR_OFS_READMODE: begin
          next_st.rd_data = {11'h000, st.row_flip,
                             st.col_bin, st.row_bin};
        end
        // Unmapped addresses read as zero.
        default:        next_st.rd_data = 16'h0000;
      endcase
    end

    // Pixel clock runs at one, one half or one quarter rate.
    next_st.pix_div = st.pix_div + 2'h1;
    case (st.col_bin)
      // Toggling keeps a strict every-other-cycle rate across mode changes.
      EKR_BIN_2: next_st.pix_en = !st.pix_en;
      EKR_BIN_4: next_st.pix_en = (next_st.pix_div == 2'h3);
      // Invalid code 3 falls back to the normal rate.
      default:   next_st.pix_en = 1'b1;
    endcase

    // Readout row address, stepping by the binning factor.
    if (frame_start_i) begin
      if (st.row_flip) begin
        next_st.row_addr = {1'b0, row_start_i}
                         + {1'b0, win_height_i};
      end else begin
        next_st.row_addr = {1'b0, row_start_i};
      end
    end else if (line_done_i) begin
      if (st.row_flip) begin
        next_st.row_addr = st.row_addr - bin_step(st.row_bin);
      end else begin
        next_st.row_addr = st.row_addr + bin_step(st.row_bin);
      end
    end

    // Exposure length source for the coming frame.
    tot = aec_en_i ? aec_rows_i : st.total;
    a2  = ratio_rows(tot, st.t2_exp);
    a3  = ratio_rows(tot, st.t3_exp);

    // Exposure sequencer.
    case (st.state)
      EKR_IDLE: begin
        next_st.gate = EKR_GATE_OFF;
      end
      EKR_EXPOSE: begin
        if (row_tick_i) begin
          nc = st.row_cnt + 15'h0001;
          next_st.row_cnt = nc;
          if (nc >= st.w_total) begin
            next_st.state = EKR_IDLE;
            next_st.gate  = EKR_GATE_OFF;
          end else begin
            next_st.gate = level_for(nc, st.w_t1, st.w_t2);
          end
        end
      end
      default: begin
        next_st.state = EKR_IDLE;
      end
    endcase

    // A frame start freezes the settings for the whole frame.
    if (frame_start_i) begin
      next_st.w_total = tot;
      if (!hdr_en_i) begin
        // Linear mode: one interval at the first level.
        next_st.w_t1 = tot;
        next_st.w_t2 = 15'h0000;
        next_st.w_t3 = 15'h0000;
      end else if (st.auto_adj) begin
        // Automatic placement from the ratio exponents.
        next_st.w_t2 = a2;
        next_st.w_t3 = st.single ? 15'h0000 : a3;
        next_st.w_t1 = sat_sub(sat_sub(tot, a2),
                               next_st.w_t3);
      end else begin
        // Manual placement from the knee row counts.
        next_st.w_t1 = st.knee1;
        if (st.single) begin
          next_st.w_t2 = sat_sub(tot, st.knee1);
          next_st.w_t3 = 15'h0000;
        end else begin
          next_st.w_t2 = sat_sub(st.knee2, st.knee1);
          next_st.w_t3 = sat_sub(tot, st.knee2);
        end
      end
      next_st.row_cnt = 15'h0000;
      next_st.state   = (tot != 15'h0000) ? EKR_EXPOSE : EKR_IDLE;
      next_st.gate    = (tot != 15'h0000) ? EKR_GATE_FIRST
                                          : EKR_GATE_OFF;
    end

    // Soft reset abandons the frame but keeps the register file.
    if (!logic_rst_n) begin
      next_st.state    = EKR_IDLE;
      next_st.row_cnt  = 15'h0000;
      next_st.gate     = EKR_GATE_OFF;
      next_st.w_t1     = 15'h0000;
      next_st.w_t2     = 15'h0000;
      next_st.w_t3     = 15'h0000;
      next_st.w_total  = 15'h0000;
      next_st.pix_div  = 2'h0;
      next_st.pix_en   = 1'b0;
      next_st.row_addr = 10'h000;
    end
  end

  // ========================================================
  // State register.
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st          <= '0;
      st.knee1    <= `EKR_RST_KNEE1;
      st.knee2    <= `EKR_RST_KNEE2;
      st.t2_exp   <= `EKR_RST_T2EXP;
      st.t3_exp   <= `EKR_RST_T3EXP;
      st.auto_adj <= `EKR_RST_AUTO;
      st.single   <= `EKR_RST_SINGLE;
      st.total    <= `EKR_RST_TOTAL;
      st.row_bin  <= ekr_bin_t'(`EKR_RST_ROWBIN);
      st.col_bin  <= ekr_bin_t'(`EKR_RST_COLBIN);
      st.row_flip <= `EKR_RST_ROWFLIP;
      st.state    <= EKR_IDLE;
      st.gate     <= EKR_GATE_OFF;
    end else begin
      st <= next_st;
    end
  end

  // ========================================================
  // Outputs from the state register; the two reset outputs come from the pulse stretchers.
  assign rdata_o       = st.rd_data;
  assign exposing_o    = (st.state == EKR_EXPOSE);
  assign gate_level_o  = st.gate;
  assign t1_rows_o     = st.w_t1;
  assign t2_rows_o     = st.w_t2;
  assign t3_rows_o     = st.w_t3;
  assign row_bin_o     = st.row_bin;
  assign col_bin_o     = st.col_bin;
  assign row_flip_o    = st.row_flip;
  assign pix_clk_en_o  = st.pix_en;
  assign row_addr_o    = st.row_addr;
  assign logic_rst_n_o = logic_rst_n;
endmodule

// >>> rtl/ekr_params.svh
`ifndef EKR_PARAMS_SVH
`define EKR_PARAMS_SVH

// ==========================================================
// Register offsets.
`define EKR_OFS_KNEE1     8'h08
`define EKR_OFS_KNEE2     8'h09
`define EKR_OFS_RATIO     8'h0A
`define EKR_OFS_TOTAL     8'h0B
`define EKR_OFS_SRST      8'h0C
`define EKR_OFS_READMODE  8'h0D

// ==========================================================
// Field positions.
`define EKR_RATIO_T2_LSB  0
`define EKR_RATIO_T3_LSB  4
`define EKR_RATIO_AUTO    8
`define EKR_RATIO_SINGLE  9
`define EKR_SRST_ALL      0
`define EKR_SRST_AUTO     1
`define EKR_RM_ROWBIN_LSB 0
`define EKR_RM_COLBIN_LSB 2
`define EKR_RM_ROWFLIP    4

// ==========================================================
// Reset values.
`define EKR_RST_KNEE1     15'h01BB
`define EKR_RST_KNEE2     15'h01D9
`define EKR_RST_T2EXP     4'h4
`define EKR_RST_T3EXP     4'h6
`define EKR_RST_AUTO      1'b1
`define EKR_RST_SINGLE    1'b0
`define EKR_RST_TOTAL     15'h01E0
`define EKR_RST_ROWBIN    2'h0
`define EKR_RST_COLBIN    2'h0
`define EKR_RST_ROWFLIP   1'b0

// ==========================================================
// Timing counts in master clock cycles.
`define EKR_SRST_CYCLES   4'hF

`endif

// >>> rtl/ekr_pkg.sv
package ekr_pkg;

  // ========================================================
  // Exposure sequencer states.
  typedef enum logic [0:0] {
    EKR_IDLE   = 1'b0,
    EKR_EXPOSE = 1'b1
  } ekr_state_t;

  // Saturation gate levels during integration.
  typedef enum logic [1:0] {
    EKR_GATE_OFF   = 2'b00,
    EKR_GATE_FIRST = 2'b01,
    EKR_GATE_SEC   = 2'b10,
    EKR_GATE_THIRD = 2'b11
  } ekr_gate_t;

  // Binning codes shared by rows and columns.
  typedef enum logic [1:0] {
    EKR_BIN_1   = 2'b00,
    EKR_BIN_2   = 2'b01,
    EKR_BIN_4   = 2'b10,
    EKR_BIN_BAD = 2'b11
  } ekr_bin_t;

  // State of the reset pulse stretcher.
  typedef struct packed {
    logic [3:0] cnt;
    logic       rst_n;
  } ekr_pulse_t;

endpackage

// >>> rtl/ekr_rst_pulse.sv
`include "ekr_params.svh"

// Stretches a one-cycle request into a fixed low reset pulse.
module ekr_rst_pulse (
  input  wire logic ref_clk_i,  // Master clock.
  input  wire logic arst_n_i,   // Asynchronous reset, low.
  input  wire logic trigger_i,  // One-cycle start request.
  output logic      rst_n_o     // Stretched reset, low.
);
  import ekr_pkg::*;

  ekr_pulse_t st;       // Registered state.
  ekr_pulse_t next_st;  // Next state.

  // ========================================================
  // Pulse counter.
  // A retrigger during the pulse restarts the full length.
  always_comb begin
    next_st = st;
    if (trigger_i) begin
      next_st.cnt   = `EKR_SRST_CYCLES;
      next_st.rst_n = 1'b0;
    end else if (st.cnt != 4'h0) begin
      next_st.cnt   = st.cnt - 4'h1;
      next_st.rst_n = (st.cnt == 4'h1);
    end
  end

  // State register.
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st <= '{cnt: 4'h0, rst_n: 1'b1};
    end else begin
      st <= next_st;
    end
  end

  assign rst_n_o = st.rst_n;
endmodule

// >>> tb/ekr_props.sv
// ==========================================================
// Checker on the top ports of the exposure and readout block.
module ekr_props (
  input wire logic        ref_clk_i,      // Master clock.
  input wire logic        arst_n_i,       // Async reset, low.
  input wire logic [7:0]  addr_i,         // Register address.
  input wire logic [15:0] wdata_i,        // Write data.
  input wire logic        wr_i,           // Write strobe.
  input wire logic        rd_i,           // Read strobe.
  input wire logic [15:0] rdata_o,        // Read data.
  input wire logic        frame_start_i,  // Frame start pulse.
  input wire logic        line_done_i,    // Readout row done.
  input wire logic [8:0]  row_start_i,    // First window row.
  input wire logic [8:0]  win_height_i,   // Window height.
  input wire logic        exposing_o,     // Integration running.
  input wire logic [1:0]  gate_level_o,   // Gate level.
  input wire logic [14:0] t1_rows_o,      // First interval.
  input wire logic [14:0] t2_rows_o,      // Second interval.
  input wire logic [1:0]  row_bin_o,      // Row binning code.
  input wire logic [1:0]  col_bin_o,      // Column binning code.
  input wire logic        row_flip_o,     // Rows bottom up.
  input wire logic        pix_clk_en_o,   // Pixel clock enable.
  input wire logic [9:0]  row_addr_o,     // Row being read.
  input wire logic        logic_rst_n_o,  // Logic reset, low.
  input wire logic        auto_rst_n_o    // Auto block reset, low.
);
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!arst_n_i);

  // ========================================================
  // Helper: the row address expected after a frame start or row.
  logic [9:0] step_w;   // Row step chosen by the binning code.
  logic [9:0] exp_row;  // Expected row address one cycle later.

  // Invalid code 3 steps by one, like normal readout.
  always_comb begin
    step_w = (row_bin_o == 2'h1) ? 10'h002 :
             (row_bin_o == 2'h2) ? 10'h004 : 10'h001;
  end

  // A frame start reloads the top or bottom row of the window.
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      exp_row <= 10'h000;
    end else if (frame_start_i) begin
      exp_row <= {1'b0, row_start_i} +
                 (row_flip_o ? {1'b0, win_height_i} : 10'h000);
    end else begin
      exp_row <= row_flip_o ? row_addr_o - step_w : row_addr_o + step_w;
    end
  end

  // ========================================================
  // Properties.
  rdata_idle_a: assert property (!$past(rd_i) |-> rdata_o == 16'h0000)
    else $error("read data seen without a read");
  unmapped_read_a: assert property (rd_i && (addr_i < 8'h08 ||
    addr_i > 8'h0D || addr_i == 8'h0C) |=> rdata_o == 16'h0000)
    else $error("reset or unmapped place read nonzero");
  srst_pulse_a: assert property (wr_i && addr_i == 8'h0C
    && wdata_i[0] |=> (!logic_rst_n_o) [*8] ##7 !logic_rst_n_o)
    else $error("soft reset pulse too short");
  srst_len_a: assert property ($rose(logic_rst_n_o)
    |-> $past(!logic_rst_n_o, 15)) else $error("soft reset not 15 cycles");
  auto_pulse_a: assert property (wr_i && addr_i == 8'h0C
    && logic_rst_n_o && wdata_i[1:0] == 2'h2 |=>
    (logic_rst_n_o && !auto_rst_n_o) ##14 !auto_rst_n_o ##1 auto_rst_n_o)
    else $error("auto reset pulse bad");
  frame_open_a: assert property (frame_start_i
    && logic_rst_n_o |=> t1_rows_o == 15'h0000
    || (exposing_o && gate_level_o == 2'h1))
    else $error("frame start did not open first interval");
  gate_off_a: assert property (
    !exposing_o |-> gate_level_o == 2'h0)
    else $error("gate active outside integration");
  gate_order_a: assert property (gate_level_o == 2'h3
    && !frame_start_i |=> gate_level_o inside {2'h3, 2'h0})
    else $error("gate left third level early");
  work_stable_a: assert property (!frame_start_i
    && logic_rst_n_o ##1 logic_rst_n_o
    |-> $stable(t1_rows_o) && $stable(t2_rows_o))
    else $error("working interval changed mid frame");
  row_step_a: assert property ((frame_start_i || line_done_i) &&
    logic_rst_n_o |=> row_addr_o == exp_row)
    else $error("row address step wrong");
  pix_full_a: assert property (col_bin_o == 2'h0
    && logic_rst_n_o ##1 col_bin_o == 2'h0 && logic_rst_n_o
    |-> pix_clk_en_o)
    else $error("pixel enable dropped in normal mode");
  pix_half_a: assert property (col_bin_o == 2'h1
    && pix_clk_en_o ##1 col_bin_o == 2'h1 |-> !pix_clk_en_o)
    else $error("pixel enable too fast in bin two");
endmodule

bind ekr_top ekr_props u_props (
  .ref_clk_i, .arst_n_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
  .frame_start_i, .line_done_i, .row_start_i, .win_height_i, .exposing_o,
  .gate_level_o, .t1_rows_o, .t2_rows_o, .row_bin_o, .col_bin_o,
  .row_flip_o, .pix_clk_en_o, .row_addr_o, .logic_rst_n_o, .auto_rst_n_o
);

// >>> tb/ekr_top_bench.sv
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin \
  err_total++; $display("BAD %s exp %h got %h", n, e, g); end end

// ==========================================================
// Self-checking bench driving every port of the block.
module ekr_top_bench;
  timeunit 1ns;
  timeprecision 100ps;
  logic        ref_clk_i  = 1'b0;     // Master clock.
  logic        arst_n_i   = 1'b0;     // Async reset, low.
  logic [7:0]  addr_i     = 8'h00;    // Register address.
  logic [15:0] wdata_i    = 16'h0000; // Write data.
  logic        wr_i       = 1'b0;     // Write strobe.
  logic        rd_i       = 1'b0;     // Read strobe.
  logic        hdr_en_i   = 1'b1;     // High dynamic range on.
  logic        aec_en_i   = 1'b0;     // Auto exposure on.
  logic [14:0] aec_rows_i = 15'h0000; // Auto exposure length.
  logic [2:0]  ev         = 3'h0;     // Line, tick, frame pulses.
  logic [8:0]  row_start_i  = 9'h000; // First window row.
  logic [8:0]  win_height_i = 9'h000; // Window height.
  logic [15:0] rdata_o;               // Read data.
  logic        exposing_o;            // Integration running.
  logic [1:0]  gate_level_o;          // Gate level.
  logic [14:0] t1_rows_o;             // First interval.
  logic [14:0] t2_rows_o;             // Second interval.
  logic [14:0] t3_rows_o;             // Third interval.
  logic        pix_clk_en_o;          // Pixel clock enable.
  logic [9:0]  row_addr_o;            // Row being read.
  wire  [4:0]  mode_o;                // Flip, column and row binning.
  logic        logic_rst_n_o;         // Logic reset, low.
  logic        auto_rst_n_o;          // Auto block reset, low.
  int          err_total = 0;         // Mismatches seen.
  int          tests_run = 0;         // Comparisons made.
  int          cyc       = 0;         // Clock cycles run.

  ekr_top u_dut (
    .ref_clk_i, .arst_n_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
    .hdr_en_i, .aec_en_i, .aec_rows_i, .frame_start_i(ev[0]),
    .row_tick_i(ev[1]), .line_done_i(ev[2]), .row_start_i, .win_height_i,
    .exposing_o, .gate_level_o, .t1_rows_o, .t2_rows_o, .t3_rows_o,
    .row_bin_o(mode_o[1:0]), .col_bin_o(mode_o[3:2]),
    .row_flip_o(mode_o[4]), .pix_clk_en_o, .row_addr_o,
    .logic_rst_n_o, .auto_rst_n_o
  );

  // Clock at 25 MHz.
  always #20 ref_clk_i = ~ref_clk_i;

  // A hang counts as a mismatch and closes the run.
  always @(posedge ref_clk_i) begin
    cyc++;
    if (cyc == 5000) begin
      err_total++;
      stop_test();
    end
  end

  // ========================================================
  // Bus and pulse tasks.
  task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
    @(posedge ref_clk_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge ref_clk_i);
    wr_i    <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe.
  task automatic rd_chk(input logic [7:0] a, input logic [15:0] e,
                        input string n);
    @(posedge ref_clk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge ref_clk_i);
    rd_i   <= 1'b0;
    #1;
    `CHK(n, e, rdata_o)
  endtask

  // One-cycle pulse on frame start, row tick or line done.
  task automatic pulse(input logic [2:0] m);
    @(posedge ref_clk_i);
    ev <= m;
    @(posedge ref_clk_i);
    ev <= 3'h0;
    #1;
  endtask

  // Counts the low cycles of one stretched reset output.
  task automatic low_len(input logic sel, output int n);
    n = 0;
    #1;
    while ((sel ? auto_rst_n_o : logic_rst_n_o) !== 1'b1 && n < 40) begin
      n++;
      @(posedge ref_clk_i);
      #1;
    end
  endtask

  // ========================================================
  // Scenarios.
  task automatic t_regs;
    rd_chk(8'h08, 16'h01BB, "knee1");
    rd_chk(8'h09, 16'h01D9, "knee2");
    rd_chk(8'h0A, 16'h0164, "ratio");
    rd_chk(8'h0B, 16'h01E0, "total");
    rd_chk(8'h0D, 16'h0000, "mode");
    wr_reg(8'h08, 16'hFFFF);
    rd_chk(8'h08, 16'h7FFF, "knee1 rw");
    wr_reg(8'h0A, 16'hFFFF);
    rd_chk(8'h0A, 16'h03FF, "ratio rw");
    wr_reg(8'h20, 16'h1234);
    rd_chk(8'h20, 16'h0000, "unmapped");
  endtask

  // Manual knees, then a write in mid-frame.
  task automatic t_manual;
    logic [1:0] g [4] = '{2'h2, 2'h3, 2'h3, 2'h0};
    wr_reg(8'h0A, 16'h0064);
    wr_reg(8'h08, 16'h0001);
    wr_reg(8'h09, 16'h0002);
    wr_reg(8'h0B, 16'h0004);
    pulse(3'h1);
    `CHK("t1", 15'h0001, t1_rows_o)
    `CHK("t2", 15'h0001, t2_rows_o)
    `CHK("t3", 15'h0002, t3_rows_o)
    wr_reg(8'h08, 16'h0003);
    `CHK("t1 held", 15'h0001, t1_rows_o)
    rd_chk(8'h08, 16'h0003, "knee1 now");
    for (int i = 0; i < 4; i++) begin
      pulse(3'h2);
      `CHK("gate", g[i], gate_level_o)
    end
    `CHK("exposing", 1'b0, exposing_o)
    pulse(3'h1);
    `CHK("t1 next", 15'h0003, t1_rows_o)
  endtask

  // Ratio exponents, auto exposure length and single knee.
  task automatic t_auto;
    wr_reg(8'h0A, 16'h0121);
    wr_reg(8'h0B, 16'h0010);
    pulse(3'h1);
    `CHK("t2 auto", 15'h0008, t2_rows_o)
    `CHK("t3 auto", 15'h0004, t3_rows_o)
    `CHK("t1 auto", 15'h0004, t1_rows_o)
    @(posedge ref_clk_i);
    aec_en_i   <= 1'b1;
    aec_rows_i <= 15'h0020;
    pulse(3'h1);
    `CHK("t2 aec", 15'h0010, t2_rows_o)
    `CHK("t1 aec", 15'h0008, t1_rows_o)
    @(posedge ref_clk_i);
    hdr_en_i <= 1'b0;
    pulse(3'h1);
    `CHK("t1 linear", 15'h0020, t1_rows_o)
    wr_reg(8'h0A, 16'h0200);
    hdr_en_i <= 1'b1;
    aec_en_i <= 1'b0;
    pulse(3'h1);
    `CHK("t2 single", 15'h000D, t2_rows_o)
    `CHK("t3 single", 15'h0000, t3_rows_o)
  endtask

  // Soft reset abandons the frame; the auto reset stands alone.
  task automatic t_reset;
    int n;
    wr_reg(8'h0C, 16'h0001);
    low_len(1'b0, n);
    `CHK("logic rst len", 15, n)
    `CHK("abandoned", 1'b0, exposing_o)
    rd_chk(8'h0C, 16'h0000, "rst reads");
    rd_chk(8'h0B, 16'h0010, "kept total");
    wr_reg(8'h0C, 16'h0002);
    #1;
    `CHK("logic kept", 1'b1, logic_rst_n_o)
    low_len(1'b1, n);
    `CHK("auto rst len", 15, n)
  endtask

  // Row binning, row flip and column binning.
  task automatic t_read;
    int n;
    wr_reg(8'h0D, 16'h0001);
    row_start_i  <= 9'h00A;
    win_height_i <= 9'h014;
    pulse(3'h1);
    `CHK("row first", 10'h00A, row_addr_o)
    pulse(3'h4);
    `CHK("row bin2", 10'h00C, row_addr_o)
    wr_reg(8'h0D, 16'h0012);
    rd_chk(8'h0D, 16'h0012, "mode rw");
    `CHK("mode out", 5'h12, mode_o)
    pulse(3'h1);
    `CHK("row flip", 10'h01E, row_addr_o)
    pulse(3'h4);
    `CHK("row bin4", 10'h01A, row_addr_o)
    for (int c = 0; c < 4; c++) begin
      wr_reg(8'h0D, {12'h000, c[1:0], 2'h0});
      repeat (4) @(posedge ref_clk_i);
      `CHK("col bin out", c[1:0], mode_o[3:2])
      n = 0;
      repeat (8) begin
        @(posedge ref_clk_i);
        #1;
        n += int'(pix_clk_en_o);
      end
      `CHK("pix rate", (c == 1) ? 4 : (c == 2) ? 2 : 8, n)
    end
  endtask

  // ========================================================
  // Verdict and end of run.
  task automatic stop_test;
    if (err_total == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Main sequence.
  initial begin
    repeat (5) @(posedge ref_clk_i);
    arst_n_i <= 1'b1;
    t_regs();
    t_manual();
    t_auto();
    t_reset();
    t_read();
    stop_test();
  end
endmodule
